// *** slpm_params.svh ***
// constants for the link power manager
`ifndef SLPM_PARAMS_SVH
`define SLPM_PARAMS_SVH
// request field encodings
`define SLPM_REQ_IDLE 4'h0
`define SLPM_REQ_ACTIVE 4'h1
`define SLPM_REQ_PARTIAL 4'h2
`define SLPM_REQ_SLUMBER 4'h6
// status encodings
`define SLPM_ST_NONE 4'h0
`define SLPM_ST_ACTIVE 4'h1
`define SLPM_ST_PARTIAL 4'h2
`define SLPM_ST_SLUMBER 4'h6
// allowed transitions encodings
`define SLPM_ALW_ALL 4'h0
`define SLPM_ALW_NO_PARTIAL 4'h1
`define SLPM_ALW_NO_SLUMBER 4'h2
`define SLPM_ALW_NONE 4'h3
// recovery limits
`define SLPM_PARTIAL_EXIT_NS 10000
`define SLPM_SLUMBER_EXIT_NS 10000000
`define SLPM_CLK_NS 40
`define SLPM_PARTIAL_EXIT_CYC (`SLPM_PARTIAL_EXIT_NS / `SLPM_CLK_NS)
`define SLPM_SLUMBER_EXIT_CYC (`SLPM_SLUMBER_EXIT_NS / `SLPM_CLK_NS)
`define SLPM_TMR_W 24
`endif

// *** slpm_pkg.sv ***
// types for the link power manager
package slpm_pkg;
    typedef enum logic [2:0] {
        SLPM_ACTIVE,
        SLPM_REQ_WAIT,
        SLPM_LOW,
        SLPM_WAKING
    } slpm_state_e;

    // primitives seen on the link
    typedef struct packed {
        logic pm_partial;
        logic pm_slumber;
        logic pm_ack;
        logic pm_nack;
        logic comwake;
    } slpm_link_rx_s;

    // primitives sent on the link
    typedef struct packed {
        logic pm_partial;
        logic pm_slumber;
        logic pm_ack;
        logic pm_nack;
        logic comwake;
    } slpm_link_tx_s;
endpackage

// *** slpm_sync.sv ***
// two-stage synchroniser for pin inputs
`timescale 1ns/100ps
module slpm_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic clk_en_i,
    // data
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else if (clk_en_i) begin
            meta_ff <= async_i;
            sync_ff <= meta_ff;
        end
    end

    assign sync_o = sync_ff;
endmodule

// *** slpm_no_cmd_det.sv ***
// detector for the no-commands-left condition
`timescale 1ns/100ps
module slpm_no_cmd_det #(
    parameter int SLOTS = 32
) (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic clk_en_i,
    // slot registers
    input wire logic [SLOTS-1:0] issued_slots_i,
    input wire logic [SLOTS-1:0] queued_active_slots_i,
    input wire logic sdb_update_i,
    // result
    output logic no_cmd_o
);
    logic [SLOTS-1:0] prev_issued_ff;
    logic [SLOTS-1:0] prev_queued_ff;
    wire issued_drop = (prev_issued_ff != '0) && (issued_slots_i == '0);
    wire queued_drop = (prev_queued_ff != '0) && (queued_active_slots_i == '0);
    // both already zero gives no event: only a falling edge counts
    wire case_issued = (queued_active_slots_i == '0) && issued_drop;
    wire case_sdb = (issued_slots_i == '0) && queued_drop && sdb_update_i;

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            prev_issued_ff <= '0;
            prev_queued_ff <= '0;
        end else if (clk_en_i) begin
            prev_issued_ff <= issued_slots_i;
            prev_queued_ff <= queued_active_slots_i;
        end
    end

    assign no_cmd_o = clk_en_i && (case_issued || case_sdb);
endmodule

// *** slpm_link_pm.sv ***
// per-port interface link power manager
`timescale 1ns/100ps
`include "slpm_params.svh"

// Behaviour
// - adapter power states only D0, D3
// - partial exit 10us, slumber 10ms
// - power event forces link back active
// - present link state always reported
// - drive low-power request in active state gets ack/nack
// - drive requests judged by allowed transitions
// - drive request rejected while frame pending
// - software request only taken in idle
// - no direct partial to slumber move
// - auto entry capability, enable, select
// - auto entry when no commands remain
// - two ways no commands are detected
// - both zero already: no auto entry
// - wake link with comwake before sending
// - automatic request beats software request
// - request value 6h means slumber
// - allowed 3h forbids every transition the drive requests
// - allowed 0h permits both states
module slpm_link_pm import slpm_pkg::*; #(
    parameter int SLOTS = 32,
    parameter int PARTIAL_EXIT_CYC = `SLPM_PARTIAL_EXIT_CYC,
    parameter int SLUMBER_EXIT_CYC = `SLPM_SLUMBER_EXIT_CYC,
    parameter bit AUTO_CAPABLE = 1'b1,
    parameter bit PARTIAL_CAPABLE = 1'b1,
    parameter bit SLUMBER_CAPABLE = 1'b1
) (
    // clock, reset, enable
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic clk_en_i,
    // software control
    input wire logic port_run_enable_i,
    input wire logic [3:0] link_pm_request_i,
    input wire logic link_pm_request_wr_i,
    input wire logic auto_link_pm_enable_i,
    input wire logic auto_slumber_select_i,
    input wire logic [3:0] allowed_pm_transitions_i,
    input wire logic adapter_d3_i,
    input wire logic pm_event_i,
    // command state
    input wire logic [SLOTS-1:0] issued_slots_i,
    input wire logic [SLOTS-1:0] queued_active_slots_i,
    input wire logic sdb_update_i,
    input wire logic frame_pending_i,
    input wire logic link_idle_i,
    // link side (pins)
    input wire slpm_link_rx_s link_rx_i,
    input wire logic phy_ready_i,
    output slpm_link_tx_s link_tx_o,
    // status
    output logic [3:0] link_pm_state_status_o,
    output logic [3:0] link_pm_request_o,
    output logic link_active_o,
    output logic tx_allowed_o,
    output logic wake_timeout_o,
    output logic auto_link_pm_capable_o,
    output logic partial_capable_o,
    output logic slumber_capable_o,
    output logic adapter_d3_o
);
    // ----------------------------------------
    // link inputs cross from the pins
    // ----------------------------------------
    slpm_link_rx_s rx;
    logic phy_rdy;

    slpm_sync #(.WIDTH($bits(slpm_link_rx_s) + 1)) u_sync (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .clk_en_i(clk_en_i),
        .async_i({link_rx_i, phy_ready_i}),
        .sync_o({rx, phy_rdy})
    );

    logic no_cmd;

    slpm_no_cmd_det #(.SLOTS(SLOTS)) u_nocmd (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .clk_en_i(clk_en_i),
        .issued_slots_i(issued_slots_i),
        .queued_active_slots_i(queued_active_slots_i),
        .sdb_update_i(sdb_update_i),
        .no_cmd_o(no_cmd)
    );

    // ----------------------------------------
    // state registers
    // ----------------------------------------
    slpm_state_e state_ff, nxt_state;
    logic slumber_ff, nxt_slumber;
    logic [`SLPM_TMR_W-1:0] tmr_ff, nxt_tmr;
    logic [3:0] req_ff, nxt_req;
    logic timeout_ff, nxt_timeout;
    slpm_link_tx_s tx_ff, nxt_tx;
    logic d3_ff;
    logic dev_req_ff;

    // ----------------------------------------
    // decode
    // ----------------------------------------
    wire allow_none = allowed_pm_transitions_i == `SLPM_ALW_NONE;
    // value 0h permits both; 1h and 2h forbid one each
    wire allow_partial = PARTIAL_CAPABLE && !allow_none &&
                         (allowed_pm_transitions_i != `SLPM_ALW_NO_PARTIAL);
    wire allow_slumber = SLUMBER_CAPABLE && !allow_none &&
                         (allowed_pm_transitions_i != `SLPM_ALW_NO_SLUMBER);
    wire dev_req = rx.pm_partial || rx.pm_slumber;
    // the drive holds its request until our answer reaches it, so answer only the rising edge
    wire dev_req_new = dev_req && !dev_req_ff;
    wire dev_req_ok = !frame_pending_i &&
                      ((rx.pm_partial && allow_partial) || (rx.pm_slumber && allow_slumber));
    wire auto_go = AUTO_CAPABLE && auto_link_pm_enable_i && no_cmd;
    // request acted on only in its write cycle, and only when the link layer is idle
    wire sw_take = link_pm_request_wr_i && link_idle_i;
    wire sw_slumber = sw_take && (link_pm_request_i == `SLPM_REQ_SLUMBER);
    wire sw_partial = sw_take && (link_pm_request_i == `SLPM_REQ_PARTIAL);
    wire sw_active = sw_take && (link_pm_request_i == `SLPM_REQ_ACTIVE);
    wire wake_need = pm_event_i || frame_pending_i || sw_active;
    wire [`SLPM_TMR_W-1:0] exit_lim = slumber_ff ? `SLPM_TMR_W'(SLUMBER_EXIT_CYC)
                                                 : `SLPM_TMR_W'(PARTIAL_EXIT_CYC);

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        nxt_state = state_ff;
        nxt_slumber = slumber_ff;
        nxt_tmr = tmr_ff;
        nxt_timeout = timeout_ff;
        nxt_tx = '0;
        // the field always reads idle once a write has been handled
        nxt_req = link_pm_request_wr_i ? link_pm_request_i : `SLPM_REQ_IDLE;
        case (state_ff)
            SLPM_ACTIVE: begin
                if (dev_req_new) begin
                    nxt_tx.pm_ack = dev_req_ok;
                    nxt_tx.pm_nack = !dev_req_ok;
                    if (dev_req_ok) begin
                        nxt_slumber = rx.pm_slumber;
                        nxt_state = SLPM_LOW;
                    end
                end else if (auto_go) begin
                    // own request wins over a concurrent software write
                    nxt_slumber = auto_slumber_select_i;
                    nxt_tx.pm_slumber = auto_slumber_select_i;
                    nxt_tx.pm_partial = !auto_slumber_select_i;
                    nxt_state = SLPM_REQ_WAIT;
                end else if (sw_slumber || sw_partial) begin
                    nxt_slumber = sw_slumber;
                    nxt_tx.pm_slumber = sw_slumber;
                    nxt_tx.pm_partial = sw_partial;
                    nxt_state = SLPM_REQ_WAIT;
                end
            end
            SLPM_REQ_WAIT: begin
                nxt_tx.pm_slumber = slumber_ff;
                nxt_tx.pm_partial = !slumber_ff;
                if (rx.pm_ack) begin
                    nxt_tx = '0;
                    nxt_state = SLPM_LOW;
                end else if (rx.pm_nack || pm_event_i) begin
                    nxt_tx = '0;
                    nxt_state = SLPM_ACTIVE;
                end
            end
            SLPM_LOW: begin
                // software low-power writes here are dropped, never a direct swap
                if (wake_need || rx.comwake) begin
                    nxt_tx.comwake = !rx.comwake;
                    nxt_tmr = '0;
                    nxt_timeout = 1'b0;
                    nxt_state = SLPM_WAKING;
                end
            end
            SLPM_WAKING: begin
                if (phy_rdy) begin
                    nxt_state = SLPM_ACTIVE;
                end else if (tmr_ff >= exit_lim) begin
                    // report a late wake but keep waiting on the phy
                    nxt_timeout = 1'b1;
                end else begin
                    nxt_tmr = tmr_ff + `SLPM_TMR_W'(1);
                end
            end
            default: begin
                nxt_state = SLPM_ACTIVE;
            end
        endcase
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_ff <= SLPM_ACTIVE;
            slumber_ff <= 1'b0;
            tmr_ff <= '0;
            req_ff <= `SLPM_REQ_IDLE;
            timeout_ff <= 1'b0;
            tx_ff <= '0;
            d3_ff <= 1'b0;
            dev_req_ff <= 1'b0;
        end else if (clk_en_i) begin
            dev_req_ff <= dev_req;
            state_ff <= nxt_state;
            slumber_ff <= nxt_slumber;
            tmr_ff <= nxt_tmr;
            req_ff <= nxt_req;
            timeout_ff <= nxt_timeout;
            tx_ff <= nxt_tx;
            // only D0 and D3 exist; D3 is honoured only with the port stopped
            d3_ff <= adapter_d3_i && !port_run_enable_i;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    wire low = (state_ff == SLPM_LOW) || (state_ff == SLPM_WAKING);
    wire [3:0] low_code = slumber_ff ? `SLPM_ST_SLUMBER : `SLPM_ST_PARTIAL;

    assign link_pm_state_status_o = !phy_rdy && !low ? `SLPM_ST_NONE :
                                    low ? low_code : `SLPM_ST_ACTIVE;
    assign link_tx_o = tx_ff;
    assign link_pm_request_o = req_ff;
    assign link_active_o = !low;
    assign tx_allowed_o = !low && (state_ff != SLPM_REQ_WAIT) && phy_rdy;
    assign wake_timeout_o = timeout_ff;
    assign auto_link_pm_capable_o = AUTO_CAPABLE;
    assign partial_capable_o = PARTIAL_CAPABLE;
    assign slumber_capable_o = SLUMBER_CAPABLE;
    assign adapter_d3_o = d3_ff;
endmodule

// *** slpm_sync_unused_guard.sv ***
// spare file: holds no logic

// *** slpm_link_pm_monitor.sv ***
// assertions on the port behaviour of the link power manager
`timescale 1ns/100ps
`include "slpm_params.svh"
module slpm_link_pm_monitor import slpm_pkg::*; (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // watched ports
    input wire logic [3:0] link_pm_request_i,
    input wire logic link_pm_request_wr_i,
    input wire logic auto_link_pm_enable_i,
    input wire logic pm_event_i,
    input wire logic frame_pending_i,
    input wire logic link_idle_i,
    input wire logic [3:0] allowed_pm_transitions_i,
    input wire slpm_link_rx_s link_rx_i,
    input wire slpm_link_tx_s link_tx_o,
    input wire logic [3:0] link_pm_state_status_o,
    input wire logic [3:0] link_pm_request_o
);
    // ----------------
    // checks
    // ----------------
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    wire logic low_w = link_pm_state_status_o inside {`SLPM_ST_PARTIAL, `SLPM_ST_SLUMBER};
    wire logic dev_req_w = link_rx_i.pm_partial || link_rx_i.pm_slumber;
    wire logic quiet_w = !auto_link_pm_enable_i && !pm_event_i && !frame_pending_i && link_rx_i == '0;
    wire logic sw_go_w = link_pm_request_wr_i && link_tx_o == '0 && quiet_w;
    a_status_legal: assert property (link_pm_state_status_o inside {4'h0, 4'h1, 4'h2, 4'h6})
        else $error("status code outside the legal set");
    a_sw_slumber_req: assert property (sw_go_w && link_idle_i && link_pm_request_i == `SLPM_REQ_SLUMBER
        && link_pm_state_status_o == `SLPM_ST_ACTIVE |=> link_tx_o.pm_slumber)
        else $error("slumber write not turned into a request");
    a_busy_write_ignored: assert property (sw_go_w && !link_idle_i && !$past(link_pm_request_wr_i)
        |=> !link_tx_o.pm_partial && !link_tx_o.pm_slumber) else $error("write outside idle acted on");
    a_no_direct_move: assert property (link_pm_state_status_o == `SLPM_ST_SLUMBER && link_pm_request_wr_i
        && link_pm_request_i == `SLPM_REQ_PARTIAL |=> (!link_tx_o.pm_partial) [*3])
        else $error("direct slumber to partial move");
    a_none_nacks: assert property ($rose(dev_req_w) && allowed_pm_transitions_i == `SLPM_ALW_NONE
        |-> ##[1:5] link_tx_o.pm_nack) else $error("drive request not refused");
    a_pending_nacks: assert property ($rose(dev_req_w) && frame_pending_i ##1 frame_pending_i [*2]
        |-> ##[1:2] link_tx_o.pm_nack) else $error("request accepted with frame waiting");
    a_wake_before_tx: assert property ($rose(frame_pending_i) && low_w && !pm_event_i
        |-> ##[0:3] link_tx_o.comwake) else $error("no wake signal before transmission");
    a_event_wakes: assert property ($rose(pm_event_i) && low_w
        |-> ##[1:120] link_pm_state_status_o == `SLPM_ST_ACTIVE) else $error("power event did not wake link");
    a_req_field_idle: assert property (1'b1 |=> link_pm_request_o ==
        ($past(link_pm_request_wr_i) ? $past(link_pm_request_i) : 4'h0)) else $error("request field not cleared");
    c_slumber: cover property ($rose(link_pm_state_status_o == `SLPM_ST_SLUMBER));
    c_nack: cover property (link_tx_o.pm_nack);
    c_auto_partial: cover property (auto_link_pm_enable_i && $rose(link_tx_o.pm_partial));
endmodule
bind slpm_link_pm slpm_link_pm_monitor mon_u (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
    .link_pm_request_i(link_pm_request_i), .link_pm_request_wr_i(link_pm_request_wr_i),
    .auto_link_pm_enable_i(auto_link_pm_enable_i), .pm_event_i(pm_event_i), .frame_pending_i(frame_pending_i),
    .link_idle_i(link_idle_i), .allowed_pm_transitions_i(allowed_pm_transitions_i), .link_rx_i(link_rx_i),
    .link_tx_o(link_tx_o), .link_pm_state_status_o(link_pm_state_status_o), .link_pm_request_o(link_pm_request_o));

// *** slpm_drive_model.sv ***
// behavioural model of the attached drive
`timescale 1ns/100ps
module slpm_drive_model import slpm_pkg::*; (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // link
    input wire slpm_link_tx_s link_tx_i,
    output slpm_link_rx_s link_rx_o,
    output logic phy_ready_o,
    // scenario control
    input wire logic [1:0] drive_req_i,
    input wire logic [7:0] wake_dly_i
);
    // ----------------
    // link behaviour
    // ----------------
    logic low_ff;
    logic answered_ff;
    logic [7:0] wake_cnt_ff;
    wire logic host_req_w = link_tx_i.pm_partial || link_tx_i.pm_slumber;
    // phy stays down for the whole low-power stay, as a real drive does
    assign phy_ready_o = !low_ff;
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            link_rx_o <= '0;
            low_ff <= 1'b0;
            answered_ff <= 1'b0;
            wake_cnt_ff <= 8'h00;
        end else begin
            link_rx_o.pm_ack <= host_req_w && !answered_ff;
            answered_ff <= host_req_w;
            if (host_req_w && !answered_ff) begin
                low_ff <= 1'b1;
            end
            if (drive_req_i != 2'h0) begin
                link_rx_o.pm_partial <= drive_req_i[0];
                link_rx_o.pm_slumber <= drive_req_i[1];
            end else if (link_tx_i.pm_ack || link_tx_i.pm_nack) begin
                link_rx_o.pm_partial <= 1'b0;
                link_rx_o.pm_slumber <= 1'b0;
                low_ff <= link_tx_i.pm_ack;
            end
            if (link_tx_i.comwake && low_ff) begin
                wake_cnt_ff <= wake_dly_i;
            end else if (wake_cnt_ff != 8'h00) begin
                wake_cnt_ff <= wake_cnt_ff - 8'h01;
                low_ff <= (wake_cnt_ff != 8'h01);
            end
        end
    end
endmodule

// *** tb_top.sv ***
// self-checking bench for the link power manager
`timescale 1ns/100ps
`include "slpm_params.svh"
module tb_top import slpm_pkg::*;;
    // ----------------
    // stimulus and wiring
    // ----------------
    logic sys_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic run_en = 1'b1, wr = 1'b0, auto_en = 1'b0, auto_sel = 1'b0, d3 = 1'b0, pm_event = 1'b0;
    logic sdb = 1'b0, frame = 1'b0, idle = 1'b1, phy, active, txa, wto, cap_a, cap_p, cap_s, d3_o;
    logic [3:0] req = 4'h0, allowed = 4'h0, status, req_o;
    logic [31:0] issued = 32'h0, queued = 32'h0;
    logic [1:0] drv_req = 2'h0;
    logic [7:0] wake_dly = 8'h03;
    slpm_link_rx_s rx;
    slpm_link_tx_s tx;
    int n_errors = 0, samples_checked = 0, cycles = 0;
    initial forever #20 sys_clk_i = ~sys_clk_i;
    slpm_link_pm #(.PARTIAL_EXIT_CYC(10), .SLUMBER_EXIT_CYC(20)) dut_u (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
        .clk_en_i(1'b1), .port_run_enable_i(run_en), .link_pm_request_i(req), .link_pm_request_wr_i(wr),
        .auto_link_pm_enable_i(auto_en), .auto_slumber_select_i(auto_sel), .allowed_pm_transitions_i(allowed),
        .adapter_d3_i(d3), .pm_event_i(pm_event), .issued_slots_i(issued), .queued_active_slots_i(queued),
        .sdb_update_i(sdb), .frame_pending_i(frame), .link_idle_i(idle), .link_rx_i(rx), .phy_ready_i(phy),
        .link_tx_o(tx), .link_pm_state_status_o(status), .link_pm_request_o(req_o), .link_active_o(active),
        .tx_allowed_o(txa), .wake_timeout_o(wto), .auto_link_pm_capable_o(cap_a), .partial_capable_o(cap_p),
        .slumber_capable_o(cap_s), .adapter_d3_o(d3_o));
    slpm_drive_model drv_u (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .link_tx_i(tx), .link_rx_o(rx),
        .phy_ready_o(phy), .drive_req_i(drv_req), .wake_dly_i(wake_dly));
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    always @(posedge sys_clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            tally_and_finish();
        end
    end
    task automatic chk(input string what, input logic [3:0] exp, input logic [3:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge sys_clk_i);
    endtask
    task automatic wait_st(input logic [3:0] v);
        int n;
        n = 0;
        while (status !== v && n < 200) begin
            cyc(1);
            n++;
        end
        chk("status", v, status);
    endtask
    task automatic wr_req(input logic [3:0] v);
        req = v;
        wr = 1'b1;
        cyc(1);
        wr = 1'b0;
    endtask
    task automatic wake(input logic [7:0] d);
        wake_dly = d;
        pm_event = 1'b1;
        cyc(1);
        pm_event = 1'b0;
        wait_st(`SLPM_ST_ACTIVE);
    endtask
    // ----------------
    // scenarios
    // ----------------
    task automatic t_sw();
        int n;
        wr_req(`SLPM_REQ_SLUMBER);
        chk("slumber request", 4'h1, {3'h0, tx.pm_slumber});
        chk("request echo", `SLPM_REQ_SLUMBER, req_o);
        cyc(1);
        chk("request idle", `SLPM_REQ_IDLE, req_o);
        wait_st(`SLPM_ST_SLUMBER);
        chk("link active in slumber", 4'h0, {3'h0, active});
        chk("send allowed in slumber", 4'h0, {3'h0, txa});
        wr_req(`SLPM_REQ_PARTIAL);
        cyc(5);
        chk("no direct move", 4'h0, {3'h0, tx.pm_partial});
        frame = 1'b1;
        n = 0;
        while (tx.comwake !== 1'b1 && n < 10) begin
            cyc(1);
            n++;
        end
        chk("wake before frame", 4'h1, {3'h0, tx.comwake});
        wait_st(`SLPM_ST_ACTIVE);
        chk("prompt wake flag", 4'h0, {3'h0, wto});
        chk("link active again", 4'h1, {3'h0, active});
        chk("send allowed when active", 4'h1, {3'h0, txa});
        frame = 1'b0;
        idle = 1'b0;
        wr_req(`SLPM_REQ_PARTIAL);
        cyc(5);
        chk("busy write", `SLPM_ST_ACTIVE, status);
        idle = 1'b1;
        wr_req(`SLPM_REQ_PARTIAL);
        wait_st(`SLPM_ST_PARTIAL);
        wake(8'h28);
        chk("slow wake flag", 4'h1, {3'h0, wto});
    endtask
    task automatic t_drive();
        logic acc;
        int n;
        for (int k = 0; k < 9; k++) begin
            allowed = (k == 8) ? 4'h0 : 4'(k / 2);
            frame = (k == 8);
            acc = (k == 0 || k == 1 || k == 3 || k == 4) ? 1'b1 : 1'b0;
            drv_req = (k % 2 == 1) ? 2'h2 : 2'h1;
            cyc(1);
            drv_req = 2'h0;
            n = 0;
            while (tx.pm_ack !== 1'b1 && tx.pm_nack !== 1'b1 && n < 12) begin
                cyc(1);
                n++;
            end
            chk("drive answer", acc ? 4'h2 : 4'h1, {2'h0, tx.pm_ack, tx.pm_nack});
            frame = 1'b0;
            if (acc) begin
                wait_st((k % 2 == 1) ? `SLPM_ST_SLUMBER : `SLPM_ST_PARTIAL);
                wake(8'h03);
            end
            cyc(3);
        end
        allowed = `SLPM_ALW_ALL;
    endtask
    task automatic t_auto();
        chk("capabilities", 4'h7, {1'b0, cap_a, cap_p, cap_s});
        auto_en = 1'b1;
        issued = 32'h1;
        cyc(2);
        issued = 32'h0;
        wait_st(`SLPM_ST_PARTIAL);
        wake(8'h03);
        auto_sel = 1'b1;
        queued = 32'h1;
        cyc(2);
        queued = 32'h0;
        sdb = 1'b1;
        req = `SLPM_REQ_PARTIAL;
        wr = 1'b1;
        cyc(1);
        sdb = 1'b0;
        wr = 1'b0;
        wait_st(`SLPM_ST_SLUMBER);
        wr_req(`SLPM_REQ_ACTIVE);
        wait_st(`SLPM_ST_ACTIVE);
        cyc(20);
        chk("no repeat entry", `SLPM_ST_ACTIVE, status);
        auto_en = 1'b0;
        run_en = 1'b0;
        d3 = 1'b1;
        cyc(3);
        chk("adapter d3", 4'h1, {3'h0, d3_o});
    endtask
    initial begin
        cyc(5);
        rst_i = 1'b0;
        cyc(4);
        wait_st(`SLPM_ST_ACTIVE);
        t_sw();
        t_drive();
        t_auto();
        tally_and_finish();
    end
endmodule
